// [rtl/snpc_params.svh]
`ifndef SNPC_PARAMS_SVH
`define SNPC_PARAMS_SVH

// Serial frame geometry, counted in falling edges of the link clock.
`define SNPC_CMD_LAST       5'h05
`define SNPC_FRAME_LAST     5'h0F
`define SNPC_DATA_FIRST     5'h01
`define SNPC_DATA_LAST      5'h0E
`define SNPC_CNT_ONE        5'h01
`define SNPC_WORD_BITS      14
`define SNPC_BYTE_BITS      8

// Command codes, low five bits; the top bit of each six-bit command is ignored.
`define SNPC_CMD_LOAD_CFG   5'h00
`define SNPC_CMD_LOAD_PROG  5'h02
`define SNPC_CMD_LOAD_DATA  5'h03
`define SNPC_CMD_READ_PROG  5'h04
`define SNPC_CMD_READ_DATA  5'h05
`define SNPC_CMD_INC_ADDR   5'h06
`define SNPC_CMD_RST_ADDR   5'h16
`define SNPC_CMD_BEGIN_INT  5'h08
`define SNPC_CMD_BEGIN_EXT  5'h18
`define SNPC_CMD_END_EXT    5'h0A
`define SNPC_CMD_BULK_PROG  5'h09
`define SNPC_CMD_BULK_DATA  5'h0B
`define SNPC_CMD_ROW_ERASE  5'h11

// Address map of the address counter.
`define SNPC_ADDR_ZERO      16'h0000
`define SNPC_ADDR_PROG_TOP  16'h7FFF
`define SNPC_ADDR_CFG_BASE  16'h8000
`define SNPC_ADDR_UID_TOP   16'h8008
`define SNPC_ADDR_TOP       16'hFFFF
`define SNPC_ADDR_CFGW_LO   16'h8007
`define SNPC_ADDR_CFGW_HI   16'h800A

// Core clock period and default programming times.
`define SNPC_CLK_PERIOD_NS  50
`define SNPC_NS_PER_US      1000
`define SNPC_INT_PROG_US    2500
`define SNPC_BULK_ERASE_US  5000
`define SNPC_ROW_ERASE_US   2500

`endif

// [rtl/snpc_pkg.sv]
package snpc_pkg;
	`include "snpc_params.svh"

	// Core sequencer states.
	typedef enum logic [1:0] {
		SNPC_ST_IDLE  = 2'b00,
		SNPC_ST_READ  = 2'b01,
		SNPC_ST_TIMED = 2'b10,
		SNPC_ST_EXT   = 2'b11
	} snpc_core_state_t;

	// Link framing phase.
	typedef enum logic {
		SNPC_PH_CMD  = 1'b0,
		SNPC_PH_DATA = 1'b1
	} snpc_phase_t;

	// Operation presented to the memory array.
	typedef enum logic [3:0] {
		SNPC_OP_NONE       = 4'b0000,
		SNPC_OP_RD_PROG    = 4'b0001,
		SNPC_OP_RD_DATA    = 4'b0010,
		SNPC_OP_WR_PROG    = 4'b0011,
		SNPC_OP_WR_DATA    = 4'b0100,
		SNPC_OP_EW_DATA    = 4'b0101,
		SNPC_OP_BULK_PROG  = 4'b0110,
		SNPC_OP_BULK_DATA  = 4'b0111,
		SNPC_OP_ROW_ERASE  = 4'b1000,
		SNPC_OP_UID_ERASE  = 4'b1001
	} snpc_op_t;

endpackage : snpc_pkg

// [rtl/snpc_engine.sv]
`timescale 1ns/1ps
`include "snpc_params.svh"

module snpc_engine
	import snpc_pkg::*;
#(
	parameter int unsigned INT_PROG_CYC =
		(`SNPC_INT_PROG_US * `SNPC_NS_PER_US + `SNPC_CLK_PERIOD_NS - 1) / `SNPC_CLK_PERIOD_NS,
	parameter int unsigned BULK_ERASE_CYC =
		(`SNPC_BULK_ERASE_US * `SNPC_NS_PER_US + `SNPC_CLK_PERIOD_NS - 1) / `SNPC_CLK_PERIOD_NS,
	parameter int unsigned ROW_ERASE_CYC =
		(`SNPC_ROW_ERASE_US * `SNPC_NS_PER_US + `SNPC_CLK_PERIOD_NS - 1) / `SNPC_CLK_PERIOD_NS
) (
	// Core clock and reset.
	input  wire logic         clk,
	input  wire logic         reset,
	// Serial link, clocked by the programmer.
	input  wire logic         serial_clock_pin,
	input  wire logic         serial_data_pin_in,
	output logic              serial_data_pin_out,
	output logic              serial_data_pin_oe,
	// Protection bits from the configuration word, low means protected.
	input  wire logic         program_protect_bit_n,
	input  wire logic         data_protect_bit_n,
	// Memory array port.
	output logic              nvm_start,
	output logic [3:0]        nvm_op,
	output logic              nvm_active,
	output logic [15:0]       nvm_addr,
	output logic [111:0]      nvm_wdata,
	output logic              nvm_erase_uid,
	output logic              nvm_erase_data,
	input  wire logic [13:0]  nvm_rdata
);

	// Link state, advanced on falling edges where the data pin is sampled.
	typedef struct packed {
		logic        rst_meta;     // First reset synchroniser stage.
		logic        rst_sync;     // Second reset synchroniser stage.
		snpc_phase_t phase;        // Command or data phase.
		logic [4:0]  cnt;          // Falling edges seen in this phase.
		logic [15:0] shreg;        // Right-shifting receive register.
		logic [4:0]  code;         // Command waiting for its data phase.
		logic        rd_prog;      // Current data phase is a program read.
		logic        rd_data;      // Current data phase is a data read.
		logic        oe_fall;      // Pin drive for program reads.
		logic        req_tgl;      // Toggles once per request to the core.
		logic [4:0]  req_code;     // Request command, stable while pending.
		logic [13:0] req_data;     // Request data, stable while pending.
	} snpc_link_t;

	// Launch state, advanced on rising edges where the data pin changes.
	typedef struct packed {
		logic oe_rise;             // Pin drive for data reads.
		logic dout;                // Bit presented on the pin.
	} snpc_drive_t;

	// Core sequencer state on the system clock.
	typedef struct packed {
		logic             tgl_meta;  // First request synchroniser stage.
		logic             tgl_sync;  // Second request synchroniser stage.
		logic             tgl_seen;  // Last request toggle served.
		snpc_core_state_t state;     // Sequencer state.
		logic [15:0]      addr;      // Address counter.
		logic [7:0][13:0] latch;     // Eight-word write latches.
		logic [7:0]       dlatch;    // Data memory byte latch.
		logic             load_data; // Last load targeted data memory.
		logic [13:0]      rd_word;   // Word returned on reads.
		logic [23:0]      timer;     // Internal write or erase timer.
		logic             mem_start;
		snpc_op_t         mem_op;
		logic             mem_active;
		logic [15:0]      mem_addr;
		logic [7:0][13:0] mem_wdata;
		logic             mem_uid;
		logic             mem_data;
	} snpc_core_t;

	snpc_link_t  lk_reg;       // Link registers.
	snpc_link_t  lk_next;      // Next link value.
	snpc_drive_t dr_reg;       // Launch registers.
	snpc_drive_t dr_next;      // Next launch value.
	snpc_core_t  cc_reg;       // Core registers.
	snpc_core_t  cc_next;      // Next core value.
	logic        take;         // Core accepts a request this cycle.
	logic        prog_prot;    // Program memory protection active.
	logic        data_prot;    // Data memory protection active.

	// True for commands followed by a sixteen-clock data phase.
	function automatic logic has_data(input logic [4:0] c);
		has_data = (c == `SNPC_CMD_LOAD_CFG) || (c == `SNPC_CMD_LOAD_PROG) ||
			(c == `SNPC_CMD_LOAD_DATA) || (c == `SNPC_CMD_READ_PROG) ||
			(c == `SNPC_CMD_READ_DATA);
	endfunction : has_data

	// True when the address lies in user program memory.
	function automatic logic in_prog(input logic [15:0] a);
		in_prog = (a <= `SNPC_ADDR_PROG_TOP);
	endfunction : in_prog

	// True when the address lies in the user ID window of configuration space.
	function automatic logic in_uid(input logic [15:0] a);
		in_uid = (a >= `SNPC_ADDR_CFG_BASE) && (a <= `SNPC_ADDR_UID_TOP);
	endfunction : in_uid

	// True when the address names a configuration or calibration word.
	function automatic logic in_cfgw(input logic [15:0] a);
		in_cfgw = (a >= `SNPC_ADDR_CFGW_LO) && (a <= `SNPC_ADDR_CFGW_HI);
	endfunction : in_cfgw

	assign prog_prot = !program_protect_bit_n;
	assign data_prot = !data_protect_bit_n;

	// Link framing: bits arrive LSb first and are sampled on the falling edge.
	// The reset level is brought over by two flops; it only acts while the
	// programmer clocks, since this clock stands still outside frames.
	always_comb begin
		logic [15:0] sh;
		sh = {serial_data_pin_in, lk_reg.shreg[15:1]};
		lk_next = lk_reg;
		lk_next.rst_meta = reset;
		lk_next.rst_sync = lk_reg.rst_meta;
		if (lk_reg.rst_sync) begin
			lk_next.phase = SNPC_PH_CMD;
			lk_next.cnt = '0;
			lk_next.oe_fall = 1'b0;
			lk_next.rd_prog = 1'b0;
			lk_next.rd_data = 1'b0;
			lk_next.req_tgl = 1'b0;
		end else begin
			lk_next.shreg = sh;
			lk_next.cnt = lk_reg.cnt + `SNPC_CNT_ONE;
			unique case (lk_reg.phase)
				SNPC_PH_CMD: begin
					// Six command bits end here; the sixth bit sits at the top.
					if (lk_reg.cnt == `SNPC_CMD_LAST) begin
						lk_next.cnt = '0;
						lk_next.code = sh[14:10];
						if (has_data(sh[14:10])) begin
							lk_next.phase = SNPC_PH_DATA;
							lk_next.rd_prog = (sh[14:10] == `SNPC_CMD_READ_PROG);
							lk_next.rd_data = (sh[14:10] == `SNPC_CMD_READ_DATA);
						end
						// Reads are posted at once so the word is ready in the delay.
						if (!has_data(sh[14:10]) || (sh[14:10] == `SNPC_CMD_READ_PROG) ||
							(sh[14:10] == `SNPC_CMD_READ_DATA)) begin
							lk_next.req_code = sh[14:10];
							lk_next.req_tgl = !lk_reg.req_tgl;
						end
					end
				end
				SNPC_PH_DATA: begin
					// Program reads take the pin on the first falling edge.
					if ((lk_reg.cnt == '0) && lk_reg.rd_prog) begin
						lk_next.oe_fall = 1'b1;
					end
					// Sixteenth falling edge: frame done, pin released.
					if (lk_reg.cnt == `SNPC_FRAME_LAST) begin
						lk_next.phase = SNPC_PH_CMD;
						lk_next.cnt = '0;
						lk_next.oe_fall = 1'b0;
						lk_next.rd_prog = 1'b0;
						lk_next.rd_data = 1'b0;
						if (!lk_reg.rd_prog && !lk_reg.rd_data) begin
							lk_next.req_code = lk_reg.code;
							lk_next.req_data = sh[14:1];
							lk_next.req_tgl = !lk_reg.req_tgl;
						end
					end
				end
			endcase
		end
	end

	always_ff @(negedge serial_clock_pin) begin
		lk_reg <= lk_next;
	end

	// Launch on rising edges. At rising edge k of a data phase the falling
	// count is k-1, so data bits go out on rising edges 2 to 15.
	// The read word is held still by the core from the read command onward,
	// and the command-to-data delay covers its settling.
	always_comb begin
		logic in_bits;
		in_bits = (lk_reg.phase == SNPC_PH_DATA) && (lk_reg.cnt >= `SNPC_DATA_FIRST) &&
			(lk_reg.cnt <= `SNPC_DATA_LAST);
		dr_next.dout = 1'b0;
		if (in_bits) begin
			dr_next.dout = cc_reg.rd_word[4'(lk_reg.cnt - `SNPC_CNT_ONE)];
		end
		dr_next.oe_rise = in_bits && lk_reg.rd_data && !lk_reg.rst_sync;
	end

	always_ff @(posedge serial_clock_pin) begin
		dr_reg <= dr_next;
	end

	// The pin enable merges the two edge-aligned enables; each is a flop.
	assign serial_data_pin_out = dr_reg.dout;
	assign serial_data_pin_oe  = lk_reg.oe_fall | dr_reg.oe_rise;

	// Core sequencer. Requests cross by toggle; the command and data words
	// stay still in the link registers until the next request.
	always_comb begin
		logic [15:0] aligned;
		aligned = {cc_reg.addr[15:3], 3'b000};
		cc_next = cc_reg;
		take = 1'b0;
		cc_next.tgl_meta = lk_reg.req_tgl;
		cc_next.tgl_sync = cc_reg.tgl_meta;
		cc_next.mem_start = 1'b0;
		unique case (cc_reg.state)
			SNPC_ST_IDLE: begin
				if (cc_reg.tgl_sync != cc_reg.tgl_seen) begin
					take = 1'b1;
					cc_next.tgl_seen = cc_reg.tgl_sync;
					cc_next.mem_addr = cc_reg.addr;
					case (lk_reg.req_code)
						`SNPC_CMD_LOAD_CFG: begin
							cc_next.addr = `SNPC_ADDR_CFG_BASE;
							cc_next.latch[3'b000] = lk_reg.req_data;
							cc_next.load_data = 1'b0;
						end
						`SNPC_CMD_LOAD_PROG: begin
							// A later load to the same slot simply replaces it.
							cc_next.latch[cc_reg.addr[2:0]] = lk_reg.req_data;
							cc_next.load_data = 1'b0;
						end
						`SNPC_CMD_LOAD_DATA: begin
							cc_next.dlatch = lk_reg.req_data[`SNPC_BYTE_BITS-1:0];
							cc_next.load_data = 1'b1;
						end
						`SNPC_CMD_READ_PROG: begin
							cc_next.mem_op = SNPC_OP_RD_PROG;
							cc_next.mem_start = 1'b1;
							cc_next.state = SNPC_ST_READ;
						end
						`SNPC_CMD_READ_DATA: begin
							cc_next.mem_op = SNPC_OP_RD_DATA;
							cc_next.mem_start = 1'b1;
							cc_next.state = SNPC_ST_READ;
						end
						`SNPC_CMD_INC_ADDR: begin
							if (cc_reg.addr == `SNPC_ADDR_PROG_TOP) begin
								cc_next.addr = `SNPC_ADDR_ZERO;
							end else if (cc_reg.addr == `SNPC_ADDR_TOP) begin
								cc_next.addr = `SNPC_ADDR_CFG_BASE;
							end else begin
								cc_next.addr = cc_reg.addr + 16'h0001;
							end
						end
						`SNPC_CMD_RST_ADDR: begin
							cc_next.addr = `SNPC_ADDR_ZERO;
						end
						`SNPC_CMD_BEGIN_INT: begin
							// Data memory is erased before it is written; program
							// memory is written as is.
							cc_next.timer = 24'(INT_PROG_CYC);
							cc_next.mem_wdata = cc_reg.latch;
							cc_next.mem_wdata[0] = {6'h00, cc_reg.dlatch};
							if (cc_reg.load_data) begin
								if (!data_prot) begin
									cc_next.mem_op = SNPC_OP_EW_DATA;
									cc_next.mem_start = 1'b1;
									cc_next.mem_active = 1'b1;
									cc_next.state = SNPC_ST_TIMED;
								end
							end else if (!(prog_prot && in_prog(cc_reg.addr))) begin
								cc_next.mem_op = SNPC_OP_WR_PROG;
								cc_next.mem_addr = aligned;
								cc_next.mem_wdata = cc_reg.latch;
								cc_next.mem_start = 1'b1;
								cc_next.mem_active = 1'b1;
								cc_next.state = SNPC_ST_TIMED;
							end
						end
						`SNPC_CMD_BEGIN_EXT: begin
							// Write stays open until the programmer ends it.
							cc_next.mem_wdata = cc_reg.latch;
							cc_next.mem_wdata[0] = {6'h00, cc_reg.dlatch};
							if (cc_reg.load_data) begin
								if (!data_prot) begin
									cc_next.mem_op = SNPC_OP_WR_DATA;
									cc_next.mem_start = 1'b1;
									cc_next.mem_active = 1'b1;
									cc_next.state = SNPC_ST_EXT;
								end
							end else if (!in_cfgw(cc_reg.addr) &&
								!(prog_prot && in_prog(cc_reg.addr))) begin
								cc_next.mem_op = SNPC_OP_WR_PROG;
								cc_next.mem_addr = aligned;
								cc_next.mem_wdata = cc_reg.latch;
								cc_next.mem_start = 1'b1;
								cc_next.mem_active = 1'b1;
								cc_next.state = SNPC_ST_EXT;
							end
						end
						`SNPC_CMD_BULK_PROG: begin
							// Protection does not block this; erasing the
							// configuration words is what lifts protection.
							if (in_prog(cc_reg.addr) || in_uid(cc_reg.addr)) begin
								cc_next.mem_op = SNPC_OP_BULK_PROG;
								cc_next.mem_uid = in_uid(cc_reg.addr);
								cc_next.mem_data = data_prot;
								cc_next.timer = 24'(BULK_ERASE_CYC);
								cc_next.mem_start = 1'b1;
								cc_next.mem_active = 1'b1;
								cc_next.state = SNPC_ST_TIMED;
							end
						end
						`SNPC_CMD_BULK_DATA: begin
							if (!data_prot) begin
								cc_next.mem_op = SNPC_OP_BULK_DATA;
								cc_next.timer = 24'(BULK_ERASE_CYC);
								cc_next.mem_start = 1'b1;
								cc_next.mem_active = 1'b1;
								cc_next.state = SNPC_ST_TIMED;
							end
						end
						`SNPC_CMD_ROW_ERASE: begin
							cc_next.timer = 24'(ROW_ERASE_CYC);
							if (in_uid(cc_reg.addr)) begin
								cc_next.mem_op = SNPC_OP_UID_ERASE;
								cc_next.mem_start = 1'b1;
								cc_next.mem_active = 1'b1;
								cc_next.state = SNPC_ST_TIMED;
							end else if (!(prog_prot && in_prog(cc_reg.addr))) begin
								cc_next.mem_op = SNPC_OP_ROW_ERASE;
								cc_next.mem_addr = {cc_reg.addr[15:5], 5'b00000};
								cc_next.mem_start = 1'b1;
								cc_next.mem_active = 1'b1;
								cc_next.state = SNPC_ST_TIMED;
							end
						end
						default: begin
							// Unknown codes and a stray end command do nothing.
						end
					endcase
				end
			end
			SNPC_ST_READ: begin
				// The array answers in the same cycle as the start pulse.
				cc_next.state = SNPC_ST_IDLE;
				if (cc_reg.mem_op == SNPC_OP_RD_DATA) begin
					cc_next.rd_word = data_prot ? 14'h0000 : {6'h00, nvm_rdata[7:0]};
				end else begin
					cc_next.rd_word = (prog_prot && in_prog(cc_reg.addr)) ?
						14'h0000 : nvm_rdata;
				end
			end
			SNPC_ST_TIMED: begin
				// Further commands wait here until the interval has run out.
				if (cc_reg.timer <= 24'h000001) begin
					cc_next.timer = '0;
					cc_next.mem_active = 1'b0;
					cc_next.mem_uid = 1'b0;
					cc_next.mem_data = 1'b0;
					cc_next.state = SNPC_ST_IDLE;
				end else begin
					cc_next.timer = cc_reg.timer - 24'h000001;
				end
			end
			SNPC_ST_EXT: begin
				// Only the end command is served; others stay pending.
				if ((cc_reg.tgl_sync != cc_reg.tgl_seen) &&
					(lk_reg.req_code == `SNPC_CMD_END_EXT)) begin
					cc_next.tgl_seen = cc_reg.tgl_sync;
					cc_next.mem_active = 1'b0;
					cc_next.state = SNPC_ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cc_reg <= '0;
		end else begin
			cc_reg <= cc_next;
		end
	end

	assign nvm_start      = cc_reg.mem_start;
	assign nvm_op         = cc_reg.mem_op;
	assign nvm_active     = cc_reg.mem_active;
	assign nvm_addr       = cc_reg.mem_addr;
	assign nvm_wdata      = cc_reg.mem_wdata;
	assign nvm_erase_uid  = cc_reg.mem_uid;
	assign nvm_erase_data = cc_reg.mem_data;

	// Checks on the sequencer and the link.
	chk_inc_wrap_low: assert property (@(posedge clk) disable iff (reset)
		take && (lk_reg.req_code == `SNPC_CMD_INC_ADDR) &&
		(cc_reg.addr == `SNPC_ADDR_PROG_TOP) |=> (cc_reg.addr == `SNPC_ADDR_ZERO))
		else $error("increment from 7FFFh did not wrap to zero");

	chk_inc_wrap_cfg: assert property (@(posedge clk) disable iff (reset)
		take && (lk_reg.req_code == `SNPC_CMD_INC_ADDR) &&
		(cc_reg.addr == `SNPC_ADDR_TOP) |=> (cc_reg.addr == `SNPC_ADDR_CFG_BASE))
		else $error("increment from FFFFh did not wrap to 8000h");

	chk_reset_addr: assert property (@(posedge clk) disable iff (reset)
		take && (lk_reg.req_code == `SNPC_CMD_RST_ADDR) |=> (cc_reg.addr == `SNPC_ADDR_ZERO))
		else $error("reset address did not clear the counter");

	chk_load_cfg_addr: assert property (@(posedge clk) disable iff (reset)
		take && (lk_reg.req_code == `SNPC_CMD_LOAD_CFG) |=>
		(cc_reg.addr == `SNPC_ADDR_CFG_BASE) && (cc_reg.latch[0] == $past(lk_reg.req_data)))
		else $error("load configuration did not set address and latch");

	chk_prog_read_zero: assert property (@(posedge clk) disable iff (reset)
		(cc_reg.state == SNPC_ST_READ) && (cc_reg.mem_op == SNPC_OP_RD_PROG) &&
		prog_prot && in_prog(cc_reg.addr) |=> (cc_reg.rd_word == 14'h0000))
		else $error("protected program read returned data");

	chk_data_read_byte: assert property (@(posedge clk) disable iff (reset)
		(cc_reg.state == SNPC_ST_READ) && (cc_reg.mem_op == SNPC_OP_RD_DATA) |=>
		(cc_reg.rd_word[13:8] == 6'h00) && ($past(data_prot) -> (cc_reg.rd_word == 14'h0000)))
		else $error("data read returned more than a byte or protected data");

	chk_row_protected: assert property (@(posedge clk) disable iff (reset)
		take && (lk_reg.req_code == `SNPC_CMD_ROW_ERASE) && prog_prot &&
		in_prog(cc_reg.addr) |=> !cc_reg.mem_start && (cc_reg.state == SNPC_ST_IDLE))
		else $error("row erase ran under program protection");

	chk_ext_cfg_skip: assert property (@(posedge clk) disable iff (reset)
		take && (lk_reg.req_code == `SNPC_CMD_BEGIN_EXT) && !cc_reg.load_data &&
		in_cfgw(cc_reg.addr) |=> !cc_reg.mem_start && !cc_reg.mem_active)
		else $error("external write to a configuration word was started");

	chk_bulk_hold: assert property (@(posedge clk) disable iff (reset)
		cc_reg.mem_start && (cc_reg.mem_op == SNPC_OP_BULK_PROG) |-> cc_reg.mem_active [*8])
		else $error("bulk erase released early");

	chk_prog_oe_end: assert property (@(negedge serial_clock_pin)
		disable iff (lk_reg.rst_sync)
		(lk_reg.phase == SNPC_PH_DATA) && (lk_reg.cnt == `SNPC_FRAME_LAST) |=> !lk_reg.oe_fall)
		else $error("pin still driven after sixteenth falling edge");

endmodule : snpc_engine

// [verif/snpc_prog_model.sv]
`timescale 1ns/1ps
module snpc_prog_model (
	// Serial link toward the device.
	output logic        serial_clock_pin,
	output logic        serial_data_pin_in,
	input  wire logic   serial_data_pin_out,
	input  wire logic   serial_data_pin_oe,
	// Last word read back.
	output logic [13:0] rd_word,
	output logic        rd_done
);
	logic host_en;  // Programmer drives the data line.
	logic host_bit; // Level the programmer drives.
	logic last_lvl; // Last sampled level; a released line shows its inverse.

	// A released line must not keep its stale level.
	assign serial_data_pin_in = serial_data_pin_oe ? serial_data_pin_out :
		(host_en ? host_bit : ~last_lvl);

	// Track the wire at each sampling edge.
	always @(negedge serial_clock_pin) begin
		last_lvl <= serial_data_pin_in;
	end

	initial begin
		serial_clock_pin = 1'b0;
		host_en = 1'b1;
		host_bit = 1'b0;
		last_lvl = 1'b0;
		rd_word = 14'h0000;
		rd_done = 1'b0;
	end

	// Clock out n bits, LSb first, data changed on the rising edge.
	task automatic clk_bits(input logic [15:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			serial_clock_pin = 1'b1;
			host_bit = v[i];
			#15;
			serial_clock_pin = 1'b0;
			#15;
		end
	endtask : clk_bits

	// Six-bit command, then a gap long enough for the delay and any timed op.
	task automatic command(input logic [5:0] c);
		clk_bits({10'h000, c}, 6);
		#4000;
	endtask : command

	// Data phase: start bit, fourteen bits, stop bit.
	task automatic load(input logic [13:0] w);
		clk_bits({1'b0, w, 1'b0}, 16);
		#4000;
	endtask : load

	// Sixteen read clocks with the line released; bits sampled on falls 2 to 15.
	task automatic read_word();
		host_en = 1'b0;
		for (int i = 0; i < 16; i++) begin
			serial_clock_pin = 1'b1;
			#15;
			serial_clock_pin = 1'b0;
			#1;
			if (i >= 1 && i <= 14) begin
				rd_word[i-1] = serial_data_pin_in;
			end
			#14;
		end
		host_en = 1'b1;
		rd_done = ~rd_done;
		#4000;
	endtask : read_word
endmodule : snpc_prog_model

// [verif/tb_snpc_engine.sv]
`timescale 1ns/1ps
module tb_snpc_engine;
	import snpc_pkg::*;
	logic         clk, reset, cp_n, cpd_n, start, active, uid, erd, rd_done;
	logic [13:0]  rdata, rd_word, w;
	logic [3:0]   op;
	logic [15:0]  addr;
	logic [111:0] wdata;
	wire          sclk, sdin, sdout, sdoe;
	int           mismatches, samples_checked, seed;
	logic [37:0]  exp_start[$]; // Active, erase flags, check flag, op, address, word 0.
	logic [13:0]  exp_read[$];

	always #25 clk = ~clk;

	// Short timed intervals keep the run small; the sequencing is the same.
	snpc_engine #(
		.INT_PROG_CYC          (20),
		.BULK_ERASE_CYC        (20),
		.ROW_ERASE_CYC         (20)
	) snpc_engine_inst (
		.clk                   (clk),
		.reset                 (reset),
		.serial_clock_pin      (sclk),
		.serial_data_pin_in    (sdin),
		.serial_data_pin_out   (sdout),
		.serial_data_pin_oe    (sdoe),
		.program_protect_bit_n (cp_n),
		.data_protect_bit_n    (cpd_n),
		.nvm_start             (start),
		.nvm_op                (op),
		.nvm_active            (active),
		.nvm_addr              (addr),
		.nvm_wdata             (wdata),
		.nvm_erase_uid         (uid),
		.nvm_erase_data        (erd),
		.nvm_rdata             (rdata)
	);
	snpc_prog_model snpc_prog_model_inst (
		.serial_clock_pin      (sclk),
		.serial_data_pin_in    (sdin),
		.serial_data_pin_out   (sdout),
		.serial_data_pin_oe    (sdoe),
		.rd_word               (rd_word),
		.rd_done               (rd_done)
	);

	task automatic check(input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : check

	// Word 0 is only compared for writes, where it carries the loaded word.
	task automatic cmp_start(input logic [37:0] e);
		logic [13:0] w0;
		w0 = e[34] ? wdata[13:0] : e[13:0];
		check(64'(e), 64'({active, uid, erd, e[34], op, addr, w0}));
	endtask : cmp_start

	// A read word must match the oldest expected one.
	task automatic cmp_read(input logic [13:0] e);
		check(64'(e), 64'(rd_word));
	endtask : cmp_read

	// The flags give the expected active, ID-erase and data-erase levels at the start.
	task automatic note(input logic [2:0] f, input logic c, input snpc_op_t o,
		input logic [15:0] a);
		exp_start.push_back({f, c, 4'(o), a, c ? w : 14'h0000});
	endtask : note

	task automatic set_prot(input logic cp, input logic data_protect_bit);
		@(posedge clk);
		cp_n <= cp;
		cpd_n <= data_protect_bit;
	endtask : set_prot

	task tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Every start must match the oldest expected one; an extra start is a refusal missed.
	// Looked at on the falling edge, where the core's outputs stand still.
	always @(negedge clk) begin
		if (start === 1'b1) begin
			if (exp_start.size() == 0) check(64'h0, 64'(op));
			else cmp_start(exp_start.pop_front());
		end
	end

	// The first change of the done flag at start-up is not a read.
	always @(rd_done) begin
		if (reset === 1'b0) begin
			if (exp_read.size() == 0) check(64'h0, 64'h1);
			else cmp_read(exp_read.pop_front());
		end
	end

	initial begin
		clk = 1'b0; reset = 1'b1; cp_n = 1'b1; cpd_n = 1'b1;
		rdata = 14'h0000; w = 14'h0000; seed = 32'he19a;
		mismatches = 0; samples_checked = 0;
		// Let the partner set its idle levels before the link clock runs.
		@(posedge clk);
		snpc_prog_model_inst.clk_bits(16'h0000, 3);
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		rdata <= 14'($random(seed));
		w = 14'($random(seed));
		// The link reset flops only move on link edges; two idle pulses flush them.
		snpc_prog_model_inst.clk_bits(16'h0000, 2);
		repeat (3) @(posedge clk);
		note(3'b000, 1'b0, SNPC_OP_RD_PROG, 16'h0000);
		exp_read.push_back(rdata);
		snpc_prog_model_inst.command(6'h04);
		snpc_prog_model_inst.read_word();
		set_prot(1'b0, 1'b0);
		note(3'b000, 1'b0, SNPC_OP_RD_PROG, 16'h0000);
		exp_read.push_back(14'h0000);
		snpc_prog_model_inst.command(6'h04);
		snpc_prog_model_inst.read_word();
		snpc_prog_model_inst.command(6'h11);
		snpc_prog_model_inst.command(6'h0B);
		set_prot(1'b1, 1'b1);
		note(3'b100, 1'b1, SNPC_OP_WR_PROG, 16'h0000);
		snpc_prog_model_inst.command(6'h02);
		snpc_prog_model_inst.load(w);
		snpc_prog_model_inst.command(6'h08);
		w = ~w;
		note(3'b100, 1'b1, SNPC_OP_WR_PROG, 16'h8000);
		snpc_prog_model_inst.command(6'h00);
		snpc_prog_model_inst.load(w);
		snpc_prog_model_inst.command(6'h18);
		snpc_prog_model_inst.command(6'h0A);
		// Walk up to a configuration word, where an external write must not start.
		for (int i = 0; i < 7; i++) snpc_prog_model_inst.command(6'h06);
		snpc_prog_model_inst.command(6'h18);
		note(3'b110, 1'b0, SNPC_OP_BULK_PROG, 16'h8007);
		snpc_prog_model_inst.command(6'h09);
		note(3'b101, 1'b0, SNPC_OP_BULK_PROG, 16'h0000);
		snpc_prog_model_inst.command(6'h16);
		set_prot(1'b1, 1'b0);
		snpc_prog_model_inst.command(6'h09);
		set_prot(1'b1, 1'b1);
		// Data memory keeps the low byte and is erased before the timed write.
		snpc_prog_model_inst.command(6'h06);
		w = 14'($random(seed));
		snpc_prog_model_inst.command(6'h03);
		snpc_prog_model_inst.load(w);
		w = 14'(w[7:0]);
		note(3'b100, 1'b1, SNPC_OP_EW_DATA, 16'h0001);
		snpc_prog_model_inst.command(6'h08);
		@(posedge clk);
		rdata <= 14'($random(seed));
		@(posedge clk);
		note(3'b000, 1'b0, SNPC_OP_RD_DATA, 16'h0001);
		exp_read.push_back(14'(rdata[7:0]));
		snpc_prog_model_inst.command(6'h05);
		snpc_prog_model_inst.read_word();
		note(3'b100, 1'b0, SNPC_OP_ROW_ERASE, 16'h0000);
		snpc_prog_model_inst.command(6'h11);
		for (int i = 0; i < 200 && exp_start.size() + exp_read.size() > 0; i++) @(posedge clk);
		if (exp_start.size() + exp_read.size() > 0) mismatches++;
		tally_and_finish();
	end
endmodule : tb_snpc_engine
